// [byte_stream_if.sv]
`timescale 1ns/100ps
interface byte_stream_if #(parameter int W = 8);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// [i2c_master_transmit_fsm.sv]
`timescale 1ns/100ps
`include "i2c_mt_map.svh"
module i2c_master_transmit_fsm #(
    parameter int BUF_DEPTH = 2
) (
    // clocks and reset
    input  logic       sys_clk,
    input  logic       arst_n,
    input  logic       link_clk,
    // control register writes
    input  logic       ctrl_wr,
    input  logic       ctrl_begin_condition_req,
    input  logic       ctrl_bus_release_req,
    input  logic       ctrl_ack_choice,
    input  logic       ctrl_service_flag,
    // static configuration
    input  logic       cfg_ten_bit,
    input  logic [6:0] cfg_own_addr,
    input  logic       cfg_gc_enable,
    // byte buffer register writes
    input  logic       byte_buffer_wr_valid,
    input  logic [7:0] byte_buffer_wr_data,
    output logic       byte_buffer_wr_ready,
    // status
    output logic       service_flag,
    output logic       begin_condition_req,
    output logic       bus_release_req,
    output logic       ack_choice,
    output logic [7:0] state_code_reg,
    output logic [7:0] rx_byte,
    // bus pins, open drain
    input  logic       scl_in,
    output logic       scl_out,
    output logic       scl_oe,
    input  logic       sda_in,
    output logic       sda_out,
    output logic       sda_oe
);
    import i2c_mt_pkg::*;

    sys_regs_t  sys_ff;
    sys_regs_t  nxt_sys;
    link_regs_t lk_ff;
    link_regs_t nxt_lk;
    logic [1:0] lk_rst_ff;
    logic       lk_rst_n;
    logic       go;
    logic       scl_s;
    logic       sda_s;
    logic       gc_hit;
    logic       own_hit;

    byte_stream_if #(.W(8)) wr_s ();
    byte_stream_if #(.W(8)) rd_s ();

    // software byte writes queue here; fsm drains one per byte sent
    assign wr_s.valid           = byte_buffer_wr_valid;
    assign wr_s.data            = byte_buffer_wr_data;
    assign byte_buffer_wr_ready = wr_s.ready;
    assign rd_s.ready           = (sys_ff.st == S_WAIT_BYTE);

    two_entry_buf #(
        .W     (8),
        .DEPTH (BUF_DEPTH)
    ) u_buf (
        .clk    (sys_clk),
        .arst_n (arst_n),
        .in_s   (wr_s),
        .out_s  (rd_s)
    );

    // status outputs straight from flops
    assign service_flag        = sys_ff.flag;
    assign begin_condition_req = sys_ff.begin_req;
    assign bus_release_req     = sys_ff.release_req;
    assign ack_choice          = sys_ff.ack_choice;
    assign state_code_reg      = sys_ff.code;
    assign rx_byte             = sys_ff.rx_byte;
    assign scl_out             = 1'h0;
    assign sda_out             = 1'h0;
    assign scl_oe              = lk_ff.scl_low;
    assign sda_oe              = lk_ff.sda_low;

    // status code for a finished link action, in the context of what was sent
    function automatic logic [7:0] map_code(input link_res_t res, input ctx_t ctx, input logic last_n);
        map_code = `CODE_ARB_LOST;
        unique case (res)
            R_START: map_code = `CODE_START; // RULE2
            R_ACK, R_NACK: begin
                unique case (ctx)
                    X_ADDR1: map_code = (res == R_ACK) ? `CODE_ADDR_ACK : `CODE_ADDR_NACK; // RULE5 RULE13
                    X_ADDR2: map_code = (res == R_ACK) ? `CODE_ADDR2_ACK : `CODE_ADDR2_NACK; // RULE14
                    X_DATA:  map_code = (res == R_ACK) ? `CODE_DATA_ACK : `CODE_DATA_NACK;
                    X_STX:   map_code = (res == R_NACK) ? `CODE_STX_NACK :
                                        (last_n ? `CODE_STX_ACK : `CODE_STX_LAST); // RULE12
                    X_SRX:   map_code = `CODE_ARB_LOST;
                endcase
            end
            R_ARB:   map_code = `CODE_ARB_LOST; // RULE10 RULE14
            R_OWN_W: map_code = `CODE_OWN_W;
            R_GC:    map_code = `CODE_GEN_CALL;
            R_OWN_R: map_code = `CODE_OWN_R;
            R_RX:    map_code = last_n ? `CODE_SRX_ACK : `CODE_SRX_NACK;
            R_STOP:  map_code = `CODE_IDLE;
        endcase
    endfunction

    // system side: software handshake and status sequencing
    always_comb begin
        nxt_sys = sys_ff;
        go = 1'h0;
        nxt_sys.res_sync = {sys_ff.res_sync[1:0], lk_ff.res_tgl};
        if (ctrl_wr) begin
            nxt_sys.begin_req   = ctrl_begin_condition_req; // RULE1
            nxt_sys.release_req = ctrl_bus_release_req;
            nxt_sys.ack_choice  = ctrl_ack_choice;
            if (!ctrl_service_flag) begin
                nxt_sys.flag = 1'h0; // RULE4
            end
        end
        unique case (sys_ff.st)
            S_IDLE: begin
                if (sys_ff.begin_req) begin
                    nxt_sys.cmd = LC_START; // RULE1 RULE10
                    nxt_sys.begin_req = 1'h0;
                    go = 1'h1;
                end
            end
            S_WAIT_BYTE: begin
                // the preloaded address or data byte leaves the buffer here
                if (rd_s.valid) begin
                    nxt_sys.tx_byte = rd_s.data; // RULE3 RULE6 RULE8
                    nxt_sys.cmd = (sys_ff.ctx == X_STX) ? LC_SLV_SEND : LC_SEND;
                    go = 1'h1;
                end
            end
            S_BUSY: begin
                if (sys_ff.res_sync[2] != sys_ff.res_sync[1]) begin
                    nxt_sys.code    = map_code(lk_ff.res, sys_ff.ctx, sys_ff.cmd_ack); // RULE17
                    nxt_sys.rx_byte = lk_ff.sh;
                    if (lk_ff.res == R_STOP) begin
                        nxt_sys.st = S_IDLE;
                    end else begin
                        nxt_sys.flag = 1'h1; // RULE2 RULE5
                        nxt_sys.st = S_FLAG;
                    end
                end
            end
            S_FLAG: begin
                // nothing moves until software clears the flag
                if (!sys_ff.flag) begin // RULE4
                    case (sys_ff.code)
                        `CODE_START: begin
                            nxt_sys.ctx = X_ADDR1;
                            nxt_sys.st = S_WAIT_BYTE;
                        end
                        `CODE_ADDR_ACK, `CODE_ADDR_NACK, `CODE_DATA_ACK, `CODE_DATA_NACK,
                        `CODE_ADDR2_ACK, `CODE_ADDR2_NACK: begin // RULE9 RULE16
                            if (sys_ff.begin_req && sys_ff.release_req) begin
                                nxt_sys.cmd = LC_STOP_START; // RULE7
                                nxt_sys.begin_req = 1'h0;
                                nxt_sys.release_req = 1'h0;
                                go = 1'h1;
                            end else if (sys_ff.begin_req) begin
                                nxt_sys.cmd = LC_RESTART; // RULE7
                                nxt_sys.begin_req = 1'h0;
                                go = 1'h1;
                            end else if (sys_ff.release_req) begin
                                nxt_sys.cmd = LC_STOP; // RULE7
                                nxt_sys.release_req = 1'h0;
                                go = 1'h1;
                            end else begin
                                nxt_sys.ctx = (cfg_ten_bit && sys_ff.ctx == X_ADDR1) ? X_ADDR2 : X_DATA; // RULE8
                                nxt_sys.st = S_WAIT_BYTE; // RULE6
                            end
                        end
                        `CODE_OWN_W, `CODE_GEN_CALL: begin
                            nxt_sys.ctx = X_SRX;
                            nxt_sys.cmd = LC_RECV; // RULE11
                            nxt_sys.cmd_ack = sys_ff.ack_choice; // RULE11
                            go = 1'h1;
                        end
                        `CODE_OWN_R: begin
                            nxt_sys.ctx = X_STX;
                            nxt_sys.cmd_ack = sys_ff.ack_choice; // RULE12
                            nxt_sys.st = S_WAIT_BYTE;
                        end
                        // lost arbitration and slave completions end here; idle retries START if asked
                        default: nxt_sys.st = S_IDLE; // RULE10
                    endcase
                end
            end
        endcase
        if (go) begin
            nxt_sys.cmd_tgl = ~sys_ff.cmd_tgl;
            nxt_sys.st = S_BUSY;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sys_ff      <= '0;
            sys_ff.st   <= S_IDLE;
            sys_ff.ctx  <= X_ADDR1;
            sys_ff.cmd  <= LC_START;
            sys_ff.code <= `CODE_IDLE;
        end else begin
            sys_ff <= nxt_sys;
        end
    end

    // link reset: asserts at once, releases on the link clock
    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n) begin
            lk_rst_ff <= 2'h0;
        end else begin
            lk_rst_ff <= {lk_rst_ff[0], 1'h1};
        end
    end
    assign lk_rst_n = lk_rst_ff[1];

    assign scl_s   = lk_ff.scl_sync[1];
    assign sda_s   = lk_ff.sda_sync[1];
    assign own_hit = (lk_ff.sh[7:1] == cfg_own_addr);
    assign gc_hit  = cfg_gc_enable && (lk_ff.sh == `GC_ADDR);

    // link side: four phases per bit; command words are held stable by the toggle handshake
    always_comb begin
        nxt_lk = lk_ff;
        nxt_lk.scl_sync = {lk_ff.scl_sync[0], scl_in};
        nxt_lk.sda_sync = {lk_ff.sda_sync[0], sda_in};
        nxt_lk.cmd_sync = {lk_ff.cmd_sync[1:0], sys_ff.cmd_tgl};
        nxt_lk.ph = lk_ff.ph + 2'h1;
        unique case (lk_ff.st)
            LK_IDLE: begin
                // scl keeps its last level here; master phases leave it low, which stretches the bus while the flag is set
                nxt_lk.ph = `PH_DRIVE;
                if (lk_ff.cmd_sync[2] != lk_ff.cmd_sync[1]) begin
                    nxt_lk.cmd       = sys_ff.cmd;
                    nxt_lk.sh        = sys_ff.tx_byte;
                    nxt_lk.do_ack    = sys_ff.cmd_ack;
                    nxt_lk.bitn      = 3'h0;
                    nxt_lk.lost      = 1'h0;
                    nxt_lk.in_ack    = 1'h0;
                    nxt_lk.addr_byte = (sys_ff.cmd == LC_SEND) && (sys_ff.ctx == X_ADDR1);
                    nxt_lk.master    = (sys_ff.cmd != LC_RECV) && (sys_ff.cmd != LC_SLV_SEND);
                    nxt_lk.listen    = (sys_ff.cmd == LC_RECV);
                    unique case (sys_ff.cmd)
                        LC_START, LC_RESTART:         nxt_lk.st = LK_START;
                        LC_STOP, LC_STOP_START:       nxt_lk.st = LK_STOP;
                        LC_SEND, LC_RECV, LC_SLV_SEND: nxt_lk.st = LK_BIT;
                    endcase
                end
            end
            LK_START: begin
                unique case (lk_ff.ph)
                    `PH_DRIVE: begin
                        nxt_lk.sda_low = 1'h0;
                        // a fresh START waits for both lines high
                        if (lk_ff.cmd == LC_START && !(scl_s && sda_s)) begin
                            nxt_lk.ph = `PH_DRIVE; // RULE1
                        end
                    end
                    `PH_RISE:   nxt_lk.scl_low = 1'h0;
                    `PH_SAMPLE: nxt_lk.sda_low = 1'h1;
                    `PH_FALL: begin
                        nxt_lk.scl_low = 1'h1;
                        nxt_lk.res = R_START;
                        nxt_lk.res_tgl = ~lk_ff.res_tgl;
                        nxt_lk.st = LK_IDLE;
                    end
                endcase
            end
            LK_STOP: begin
                unique case (lk_ff.ph)
                    `PH_DRIVE:  nxt_lk.sda_low = 1'h1;
                    `PH_RISE:   nxt_lk.scl_low = 1'h0;
                    `PH_SAMPLE: nxt_lk.sda_low = 1'h0;
                    `PH_FALL: begin
                        nxt_lk.master = 1'h0;
                        if (lk_ff.cmd == LC_STOP_START) begin
                            nxt_lk.cmd = LC_START; // RULE7
                            nxt_lk.st = LK_START;
                        end else begin
                            nxt_lk.res = R_STOP;
                            nxt_lk.res_tgl = ~lk_ff.res_tgl;
                            nxt_lk.st = LK_IDLE;
                        end
                    end
                endcase
            end
            LK_BIT: begin
                unique case (lk_ff.ph)
                    `PH_DRIVE: begin
                        if (!lk_ff.in_ack) begin
                            nxt_lk.sda_low = !lk_ff.listen && !lk_ff.lost && !lk_ff.sh[7];
                        end else if (lk_ff.listen) begin
                            nxt_lk.sda_low = lk_ff.do_ack; // RULE11 RULE15
                        end else begin
                            // after losing in the address byte, answer our own or general call
                            nxt_lk.sda_low = lk_ff.lost && lk_ff.addr_byte && (own_hit || gc_hit);
                        end
                    end
                    // pin synchroniser lags two link edges, so the bit is read at the fall
                    `PH_RISE, `PH_SAMPLE: nxt_lk.scl_low = 1'h0;
                    `PH_FALL: begin
                        nxt_lk.scl_low = lk_ff.master && !lk_ff.lost;
                        if (!lk_ff.in_ack) begin
                            // a released one read back low means another master won
                            if (lk_ff.master && !lk_ff.lost && lk_ff.sh[7] && !sda_s) begin
                                nxt_lk.lost = 1'h1;
                                nxt_lk.sda_low = 1'h0;
                            end
                            nxt_lk.sh = {lk_ff.sh[6:0], sda_s};
                            nxt_lk.bitn = lk_ff.bitn + 3'h1;
                            nxt_lk.in_ack = (lk_ff.bitn == `BIT_LAST);
                        end else begin
                            nxt_lk.ackd = !sda_s;
                            nxt_lk.sda_low = 1'h0;
                            nxt_lk.st = LK_IDLE;
                            nxt_lk.res_tgl = ~lk_ff.res_tgl;
                            if (lk_ff.lost && lk_ff.addr_byte && (own_hit || gc_hit)) begin
                                nxt_lk.res = gc_hit ? R_GC : (lk_ff.sh[0] ? R_OWN_R : R_OWN_W); // RULE11 RULE12
                            end else if (lk_ff.lost) begin
                                nxt_lk.res = R_ARB; // RULE10
                            end else if (lk_ff.listen) begin
                                nxt_lk.res = R_RX;
                            end else begin
                                nxt_lk.res = !sda_s ? R_ACK : R_NACK; // RULE6 RULE9
                            end
                            if (lk_ff.lost) begin
                                nxt_lk.master = 1'h0;
                            end
                        end
                    end
                endcase
            end
        endcase
    end

    always_ff @(posedge link_clk or negedge lk_rst_n) begin
        if (!lk_rst_n) begin
            lk_ff     <= '0;
            lk_ff.st  <= LK_IDLE;
            lk_ff.cmd <= LC_START;
            lk_ff.res <= R_STOP;
        end else begin
            lk_ff <= nxt_lk;
        end
    end
endmodule // i2c_master_transmit_fsm

// [i2c_master_transmit_fsm_tb.sv]
`timescale 1ns/100ps
module i2c_master_transmit_fsm_tb;
    import i2c_mt_pkg::*;
    logic       sys_clk = 0, link_clk = 0, arst_n = 1, ctrl_wr = 0, beg = 0, rel = 0, ten = 0, bvalid = 0, ack_en = 1;
    logic [7:0] bdata = 8'h00;
    wire        scl_oe, sda_oe, m_low, bready, flag, breq, rreq;
    wire  [7:0] code, last, rx;
    int         error_cnt = 0, n_compared = 0;
    // open-drain wires, pulled up
    wire scl = ~scl_oe;
    wire sda = ~(sda_oe | m_low);
    i2c_master_transmit_fsm i_i2c_master_transmit_fsm (.sys_clk, .arst_n, .link_clk, .ctrl_wr,
        .ctrl_begin_condition_req(beg), .ctrl_bus_release_req(rel), .ctrl_ack_choice(1'b0),
        .ctrl_service_flag(1'b0), .cfg_ten_bit(ten), .cfg_own_addr(7'h11), .cfg_gc_enable(1'b0),
        .byte_buffer_wr_valid(bvalid), .byte_buffer_wr_data(bdata), .byte_buffer_wr_ready(bready),
        .service_flag(flag), .begin_condition_req(breq), .bus_release_req(rreq), .ack_choice(),
        .state_code_reg(code), .rx_byte(rx), .scl_in(scl), .scl_out(), .scl_oe, .sda_in(sda), .sda_out(), .sda_oe);
    i2c_slave_model i_i2c_slave_model (.scl, .sda, .ack_en, .sda_low(m_low), .last_byte(last));
    always #25 sys_clk = ~sys_clk;
    // link clock offset so its edges never land on a system clock edge
    initial begin #13; forever #80 link_clk = ~link_clk; end
    task automatic chk(string nm, logic [7:0] got, logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin error_cnt++; $display("[FAIL] %s exp %h got %h", nm, exp, got); end
    endtask
    // control write; the flag bit written is always zero
    task automatic ctl(logic b, logic r);
        @(posedge sys_clk) begin ctrl_wr <= 1; beg <= b; rel <= r; end
        @(posedge sys_clk) ctrl_wr <= 0;
    endtask
    task automatic push(logic [7:0] d);
        @(posedge sys_clk) begin bvalid <= 1; bdata <= d; end
        do @(posedge sys_clk); while (bready !== 1'b1);
        bvalid <= 0;
    endtask
    // wait for the flag, then make sure it and its code stand
    task automatic wflag(logic [7:0] exp);
        @(posedge sys_clk); // let a clear written just before reach the flag
        for (int i = 0; i < 400 && flag !== 1'b1; i++) @(posedge sys_clk);
        repeat (20) @(posedge sys_clk);
        chk("flag", {7'h0, flag}, 8'h01);
        chk("code", code, exp);
    endtask
    task automatic widle;
        for (int i = 0; i < 400 && code !== 8'hf8; i++) @(posedge sys_clk);
        chk("idle", code, 8'hf8);
    endtask
    task automatic t_write7;
        push(8'h54); ctl(1, 0); wflag(8'h08);
        ctl(0, 0); wflag(8'h18); chk("addr", last, 8'h54); chk("rx", rx, 8'h54);
        push(8'ha5); ctl(0, 0); wflag(8'h28); chk("data", last, 8'ha5);
        ctl(0, 1); widle;
    endtask
    task automatic t_nack;
        ack_en <= 0;
        push(8'h54); ctl(1, 0); wflag(8'h08); ctl(0, 0); wflag(8'h20);
        ctl(1, 0); wflag(8'h08);
        push(8'h54); ctl(0, 0); wflag(8'h20); ctl(1, 1); wflag(8'h08);
        push(8'h54); ctl(0, 0); wflag(8'h20); ctl(0, 1); widle;
        ack_en <= 1;
    endtask
    // both address parts queued up front, buffer must refuse a third
    task automatic t_ten;
        ten <= 1;
        push(8'hf0); push(8'h33); @(posedge sys_clk);
        chk("full", {7'h0, bready}, 8'h00);
        ctl(1, 0); wflag(8'h08); ctl(0, 0); wflag(8'h18);
        ctl(0, 0); wflag(8'hd0); chk("addr2", last, 8'h33);
        push(8'h5a); ctl(0, 0); wflag(8'h28);
        ctl(0, 1); widle; ten <= 0;
    endtask
    task automatic give_verdict;
        $display("compared %0d errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        arst_n <= 0; // a real falling edge so both domains reset
        repeat (2) @(posedge sys_clk);
        arst_n <= 1;
        chk("rst code", code, 8'hf8);
        chk("rst rdy", {7'h0, bready}, 8'h01);
        t_write7; t_nack; t_ten; give_verdict;
    end
    // hang guard, far beyond the expected few thousand cycles
    initial begin #1_000_000; error_cnt++; give_verdict; end
endmodule // i2c_master_transmit_fsm_tb
bind i2c_master_transmit_fsm i2c_mt_asserts i_i2c_mt_asserts (.*);

// [i2c_mt_asserts.sv]
`timescale 1ns/100ps
module i2c_mt_asserts (
    // watched ports, grouped to keep the checker short
    input wire logic       sys_clk, arst_n, ctrl_wr, ctrl_begin_condition_req, ctrl_service_flag,
    input wire logic       service_flag, begin_condition_req, bus_release_req, scl_oe, sda_oe,
    input wire logic [7:0] state_code_reg
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    // software clear of the flag
    wire clr = ctrl_wr && !ctrl_service_flag;
    AST_BEGIN_TAKE: assert property (ctrl_wr && ctrl_begin_condition_req |=> begin_condition_req)
        else $error("begin request not taken");
    AST_START_CODE: assert property ($fell(begin_condition_req) && !$past(ctrl_wr) |->
        ##[1:120] service_flag && state_code_reg == 8'h08) else $error("no start code");
    AST_FLAG_HOLD: assert property (service_flag && !clr |=> service_flag) else $error("flag dropped");
    AST_FLAG_CLR: assert property (service_flag && clr |=> !service_flag) else $error("flag kept");
    AST_LINES_HOLD: assert property (service_flag ##1 service_flag |-> $stable({scl_oe, sda_oe}))
        else $error("lines moved while flag set");
    AST_STRETCH: assert property (service_flag && state_code_reg inside {8'h08, 8'h18, 8'h20, 8'hd0} |-> scl_oe)
        else $error("clock not held low");
    AST_CODE_SET: assert property ($rose(service_flag) |-> state_code_reg != 8'hf8 && state_code_reg[2:0] == 3'h0)
        else $error("bad code with flag");
    AST_STOP_IDLE: assert property ($fell(bus_release_req) && !$past(ctrl_wr) |->
        ##[1:120] state_code_reg inside {8'hf8, 8'h08}) else $error("stop not finished");
    AST_CODE_HOLD: assert property ($changed(state_code_reg) |-> service_flag || state_code_reg == 8'hf8)
        else $error("code changed without flag");
    // main outcomes seen
    cover property ($rose(service_flag) && state_code_reg == 8'h18);
    cover property ($rose(service_flag) && state_code_reg == 8'h20);
    cover property ($rose(service_flag) && state_code_reg == 8'hd0);
endmodule // i2c_mt_asserts

// [i2c_mt_map.svh]
`ifndef I2C_MT_MAP_SVH
`define I2C_MT_MAP_SVH
// Summary of operation
// RULE1: begin request issues START once bus free
// RULE2: START sent sets flag, code 08h
// RULE3: software preloads address byte, write bit zero
// RULE4: transfer waits while service flag set
// RULE5: address byte sent sets flag with outcome
// RULE6: 18h plus data byte sends data
// RULE7: 18h: restart, stop, or stop then start
// RULE8: 18h in 10-bit sends extended address
// RULE9: 20h answers exactly like 18h
// RULE10: 38h clears to idle or retries START
// RULE11: 68h/78h receive byte, ack per choice
// RULE12: B0h sends byte, ack choice marks last
// RULE13: 10-bit first part reports 18h/20h
// RULE14: 10-bit second part uses own codes
// RULE15: ack choice picks ACK or NACK driven
// RULE16: second address acked allows data or conditions
// RULE17: state code only changes at reportable state
`define CODE_START      8'h08
`define CODE_ADDR_ACK   8'h18
`define CODE_ADDR_NACK  8'h20
`define CODE_DATA_ACK   8'h28
`define CODE_DATA_NACK  8'h30
`define CODE_ARB_LOST   8'h38
`define CODE_OWN_W      8'h68
`define CODE_GEN_CALL   8'h78
`define CODE_SRX_ACK    8'h80
`define CODE_SRX_NACK   8'h88
`define CODE_OWN_R      8'hb0
`define CODE_STX_ACK    8'hb8
`define CODE_STX_NACK   8'hc0
`define CODE_STX_LAST   8'hc8
`define CODE_ADDR2_ACK  8'hd0
`define CODE_ADDR2_NACK 8'hd8
`define CODE_IDLE       8'hf8
`define PH_DRIVE        2'h0
`define PH_RISE         2'h1
`define PH_SAMPLE       2'h2
`define PH_FALL         2'h3
`define BIT_LAST        3'h7
`define GC_ADDR         8'h00
`define BYTE_RST        8'h00
`endif

// [i2c_mt_pkg.sv]
package i2c_mt_pkg;
    typedef enum logic [3:0] {S_IDLE = 4'h1, S_WAIT_BYTE = 4'h2, S_BUSY = 4'h4, S_FLAG = 4'h8} sys_state_t;
    typedef enum logic [4:0] {X_ADDR1 = 5'h01, X_ADDR2 = 5'h02, X_DATA = 5'h04, X_SRX = 5'h08,
                              X_STX = 5'h10} ctx_t;
    typedef enum logic [6:0] {LC_START = 7'h01, LC_RESTART = 7'h02, LC_STOP = 7'h04, LC_STOP_START = 7'h08,
                              LC_SEND = 7'h10, LC_RECV = 7'h20, LC_SLV_SEND = 7'h40} link_cmd_t;
    typedef enum logic [3:0] {LK_IDLE = 4'h1, LK_START = 4'h2, LK_STOP = 4'h4, LK_BIT = 4'h8} link_state_t;
    typedef enum logic [4:0] {LK_ACK = 5'h01} ack_state_t;
    typedef enum logic [8:0] {R_START = 9'h001, R_ACK = 9'h002, R_NACK = 9'h004, R_ARB = 9'h008,
                              R_OWN_W = 9'h010, R_GC = 9'h020, R_OWN_R = 9'h040, R_RX = 9'h080,
                              R_STOP = 9'h100} link_res_t;
    typedef struct packed {
        sys_state_t st;
        ctx_t       ctx;
        logic       flag;
        logic       begin_req;
        logic       release_req;
        logic       ack_choice;
        logic [7:0] code;
        link_cmd_t  cmd;
        logic [7:0] tx_byte;
        logic       cmd_ack;
        logic       cmd_tgl;
        logic [2:0] res_sync;
        logic [7:0] rx_byte;
    } sys_regs_t;
    typedef struct packed {
        logic [1:0]  scl_sync;
        logic [1:0]  sda_sync;
        logic [2:0]  cmd_sync;
        link_state_t st;
        logic        in_ack;
        link_cmd_t   cmd;
        logic [1:0]  ph;
        logic [2:0]  bitn;
        logic [7:0]  sh;
        logic        lost;
        logic        addr_byte;
        logic        master;
        logic        listen;
        logic        do_ack;
        logic        ackd;
        logic        scl_low;
        logic        sda_low;
        link_res_t   res;
        logic        res_tgl;
    } link_regs_t;
endpackage

// [i2c_slave_model.sv]
`timescale 1ns/100ps
module i2c_slave_model (
    // bus wires
    input wire logic        scl,
    input wire logic        sda,
    // acknowledge on or off
    input wire logic        ack_en,
    output logic            sda_low,
    output logic [7:0]      last_byte
);
    logic [3:0] cnt = 4'h0;
    logic [7:0] sh;
    logic       act = 1'b0;
    initial sda_low = 1'b0;
    initial last_byte = 8'h00;
    // start and stop seen while clock high
    always @(negedge sda) if (scl) begin cnt = 4'h0; act = 1'b1; end
    always @(posedge sda) if (scl) act = 1'b0;
    // msb first shift on rising clock
    always @(posedge scl) if (act && cnt < 4'h8) begin sh = {sh[6:0], sda}; cnt = cnt + 4'h1; end
    // ack slot; released at the next fall so the pull-up wins again
    always @(negedge scl) if (act) begin
        if (cnt == 4'h8) begin sda_low = ack_en; last_byte = sh; cnt = 4'h9; end
        else if (cnt == 4'h9) begin sda_low = 1'b0; cnt = 4'h0; end
    end
endmodule // i2c_slave_model

// [two_entry_buf.sv]
`timescale 1ns/100ps
module two_entry_buf #(
    parameter int W     = 8,
    parameter int DEPTH = 2
) (
    // clock and reset
    input  logic              clk,
    input  logic              arst_n,
    // fill and drain sides
    byte_stream_if.snk        in_s,
    byte_stream_if.src        out_s
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0]           wp;
        logic [AW-1:0]           rp;
        logic [AW:0]             cnt;
    } buf_regs_t;

    buf_regs_t buf_ff;
    buf_regs_t nxt_buf;
    logic      push;
    logic      pop;

    // pointer step with wrap, depth need not be a power of two
    function automatic logic [AW-1:0] step(input logic [AW-1:0] p);
        step = (p == PTR_LAST) ? '0 : p + 1'b1;
    endfunction

    // ready drops when full so the writer really stalls
    assign in_s.ready  = (buf_ff.cnt != FULL);
    assign out_s.valid = (buf_ff.cnt != '0);
    assign out_s.data  = buf_ff.mem[buf_ff.rp];
    assign push        = in_s.valid && in_s.ready;
    assign pop         = out_s.valid && out_s.ready;

    always_comb begin
        nxt_buf = buf_ff;
        if (push) begin
            nxt_buf.mem[buf_ff.wp] = in_s.data;
            nxt_buf.wp = step(buf_ff.wp);
        end
        if (pop) begin
            nxt_buf.rp = step(buf_ff.rp);
        end
        if (push && !pop) begin
            nxt_buf.cnt = buf_ff.cnt + 1'b1;
        end else if (pop && !push) begin
            nxt_buf.cnt = buf_ff.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            buf_ff <= '0;
        end else begin
            buf_ff <= nxt_buf;
        end
    end
endmodule // two_entry_buf
